// ### pkg/jlu_pkg.sv
/*
 * Shared constants and types of the register jump and link unit:
 * register map, field positions, link arithmetic and the state codes.
 * Assumes a 64-bit core with 32-bit instruction words.
 */
package jlu_pkg;

    localparam int          JLU_XLEN      = 64;
    // Register byte offsets
    localparam logic [7:0]  CTRL_OFF      = 8'h00;
    localparam logic [7:0]  STATUS_OFF    = 8'h04;
    localparam logic [7:0]  TARGET_OFF    = 8'h08;
    localparam logic [7:0]  COUNT_OFF     = 8'h0c;
    // Control fields and reset value
    localparam int          CTRL_CMP_BIT  = 0;
    localparam int          CTRL_R2_BIT   = 1;
    localparam logic [1:0]  CTRL_RST      = 2'h3;
    // Instruction fields
    localparam int          OPC_HI        = 31;
    localparam int          OPC_LO        = 26;
    localparam int          RD_HI         = 15;
    localparam int          RD_LO         = 11;
    localparam int          FN_HI         = 5;
    localparam int          HINT_HB_BIT   = 10;
    localparam int          INDEX_HI      = 25;
    localparam int          REGION_LO     = 28;
    // Link arithmetic
    localparam logic [63:0] LINK_STEP     = 64'h8;
    localparam logic [63:0] SLOT_STEP     = 64'h4;
    localparam logic [4:0]  LINK_REG_RA   = 5'h1f;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_DECERR   = 2'h3;

    typedef enum logic [1:0] {
        JLU_IDLE  = 2'b00,
        JLU_SLOT  = 2'b01,
        JLU_REDIR = 2'b10
    } jlu_state_t;

    typedef struct packed {
        logic [63:0] pc;
        logic [31:0] instr;
        logic [63:0] rs_val;
    } jlu_req_t;

    typedef struct packed {
        logic        we;
        logic [4:0]  idx;
        logic [63:0] data;
    } jlu_link_t;

endpackage

// ### rtl/jlu_hazard_track.sv
/*
 * Hazard bookkeeping for the barrier jump: splits pending hazards into
 * those raised before the jump and those raised in its delay slot.
 * Assumes set, snap and clear are one-cycle pulses from the jump unit.
 */
`timescale 1ns/100ps
`default_nettype none
module jlu_hazard_track (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic haz_set,
    input  wire logic snap,
    input  wire logic clear,
    output var  logic pending
);
    logic old_r;
    logic slot_r;
    logic in_slot_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            old_r     <= 1'b0;
            slot_r    <= 1'b0;
            in_slot_r <= 1'b0;
        end else if (clear) begin
            // Only earlier hazards go; slot hazards stay, set wins
            old_r     <= slot_r | haz_set;
            slot_r    <= 1'b0;
            in_slot_r <= 1'b0;
        end else if (snap) begin
            in_slot_r <= 1'b1;
            old_r     <= old_r | haz_set;
        end else if (haz_set) begin
            if (in_slot_r) begin
                slot_r <= 1'b1;
            end else begin
                old_r <= 1'b1;
            end
        end
    end

    always_comb pending = old_r | slot_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_slot_hazard_kept: assert property (
        clear && slot_r |=> pending)
        else $error("delay slot hazard lost at barrier");
    a_old_hazard_gone: assert property (
        clear && !slot_r && !haz_set |=> !pending)
        else $error("earlier hazard survived barrier");
endmodule // jlu_hazard_track
`default_nettype wire

// ### rtl/jlu_fetch_check.sv
/*
 * Raises the address error when a misaligned jump target is fetched.
 * Assumes fetch_valid marks each instruction fetch of the core.
 */
`timescale 1ns/100ps
`default_nettype none
module jlu_fetch_check (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic arm,
    input  wire logic err_in,
    input  wire logic fetch_valid,
    output var  logic addr_err
);
    logic armed_r;
    logic err_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_r <= 1'b0;
            err_r   <= 1'b0;
        end else if (arm) begin
            armed_r <= 1'b1;
            err_r   <= err_in;
        end else if (fetch_valid) begin
            armed_r <= 1'b0;
        end
    end

    // Fault is reported on the fetch, not on the jump
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_err <= 1'b0;
        end else begin
            addr_err <= fetch_valid & armed_r & err_r;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_err_needs_fetch: assert property (
        addr_err |-> $past(fetch_valid) && $past(armed_r))
        else $error("address error without target fetch");
endmodule // jlu_fetch_check
`default_nettype wire

// ### rtl/jlu_jump_unit.sv
/*
 * Register jump and link unit with its AXI4-Lite control registers.
 * Handles the link-register jump, its barrier form and the exchange
 * jump. Assumes the core holds the request until issue_ready, reports
 * slot_done when the delay slot completes, and pulses cp0_hazard_set.
 */
`timescale 1ns/100ps
`default_nettype none
module jlu_jump_unit
    import jlu_pkg::*;
#(
    parameter int         AW             = 8,
    parameter bit         HAS_COMPRESSED = 1'b1,
    parameter logic [5:0] OPC_SPECIAL    = 6'h00,
    parameter logic [5:0] OPC_EXCH       = 6'h1d,
    parameter logic [5:0] FN_JLR         = 6'h09
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output var  logic          s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output var  logic          s_axi_wready,
    output var  logic [1:0]    s_axi_bresp,
    output var  logic          s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output var  logic          s_axi_arready,
    output var  logic [31:0]   s_axi_rdata,
    output var  logic [1:0]    s_axi_rresp,
    output var  logic          s_axi_rvalid,
    input  wire logic          s_axi_rready,
    input  wire logic          issue_valid,
    output var  logic          issue_ready,
    input  wire jlu_req_t      issue_req,
    input  wire logic          slot_done,
    input  wire logic          cp0_hazard_set,
    input  wire logic          fetch_valid,
    output var  jlu_link_t     link_wr,
    output var  logic          redirect_valid,
    output var  logic [63:0]   redirect_pc,
    output var  logic          instr_set_select_bit,
    output var  logic          hazard_flush,
    output var  logic          hazard_pending,
    output var  logic          resv_instr_exc,
    output var  logic          addr_err_exc
);
    if (AW < 4) begin : g_bad_aw
        $error("AW too narrow for the register map");
    end

    jlu_state_t  state_r;
    logic [1:0]  ctrl_r;
    logic [31:0] jump_cnt_r;
    logic [63:0] tgt_r;
    logic        mode_pend_r;
    logic        err_pend_r;
    logic        barrier_r;
    logic        exch_r;

    // Decode of the offered request
    logic [5:0]  opc;
    logic        is_jlr;
    logic        is_exch;
    logic        cmp_on;
    logic        take;
    logic        jump_go;
    logic        barrier_dec;
    logic [63:0] slot_pc;
    logic [63:0] link_sum;
    logic [63:0] tgt_nxt;
    logic        mode_nxt;
    logic        err_nxt;

    always_comb begin
        opc      = issue_req.instr[OPC_HI:OPC_LO];
        is_jlr   = (opc == OPC_SPECIAL)
                   && (issue_req.instr[FN_HI:0] == FN_JLR);
        is_exch  = (opc == OPC_EXCH);
        cmp_on   = HAS_COMPRESSED && ctrl_r[CTRL_CMP_BIT];
        take     = issue_valid && issue_ready;
        jump_go  = take && (is_jlr || (is_exch && cmp_on));
        slot_pc  = issue_req.pc + SLOT_STEP;
        link_sum = issue_req.pc + LINK_STEP;
    end

    // No privilege input: the barrier is honoured in any mode. In
    // release one mode the hint is ignored and default handling holds.
    always_comb begin
        barrier_dec = is_jlr && ctrl_r[CTRL_R2_BIT]
                      && issue_req.instr[HINT_HB_BIT];
    end

    always_comb begin
        if (is_exch) begin
            tgt_nxt  = {slot_pc[63:REGION_LO],
                        issue_req.instr[INDEX_HI:0], 2'b00};
            mode_nxt = ~instr_set_select_bit;
            err_nxt  = 1'b0;
        end else begin
            tgt_nxt  = {issue_req.rs_val[63:1], 1'b0};
            mode_nxt = cmp_on ? issue_req.rs_val[0]
                              : instr_set_select_bit;
            // Bit 0 is dropped, so only bit 1 can misalign the target
            err_nxt  = cmp_on ? (!issue_req.rs_val[0]
                                 && issue_req.rs_val[1])
                              : issue_req.rs_val[1];
        end
    end

    always_comb issue_ready = (state_r == JLU_IDLE);

    // Sequencer: jump, delay slot, redirect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= JLU_IDLE;
        end else begin
            unique case (state_r)
                JLU_IDLE: begin
                    if (jump_go) begin
                        state_r <= JLU_SLOT;
                    end
                end
                JLU_SLOT: begin
                    // The slot is a plain instruction, never a transfer
                    if (slot_done) begin
                        state_r <= JLU_REDIR;
                    end
                end
                JLU_REDIR: begin
                    state_r <= JLU_IDLE;
                end
                default: begin
                    state_r <= JLU_IDLE;
                end
            endcase
        end
    end

    // Jump capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tgt_r       <= '0;
            mode_pend_r <= 1'b0;
            err_pend_r  <= 1'b0;
            barrier_r   <= 1'b0;
            exch_r      <= 1'b0;
        end else if (jump_go) begin
            tgt_r       <= tgt_nxt;
            mode_pend_r <= mode_nxt;
            err_pend_r  <= err_nxt;
            barrier_r   <= barrier_dec;
            exch_r      <= is_exch;
        end
    end

    // Link write in the cycle after the jump is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_wr <= '0;
        end else begin
            link_wr.we <= jump_go;
            if (jump_go && is_exch) begin
                link_wr.idx  <= LINK_REG_RA;
                link_wr.data <= {link_sum[63:1],
                                 instr_set_select_bit};
            end else if (jump_go) begin
                link_wr.idx  <= issue_req.instr[RD_HI:RD_LO];
                link_wr.data <= link_sum;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resv_instr_exc <= 1'b0;
        end else begin
            resv_instr_exc <= take && is_exch && !cmp_on;
        end
    end

    // Redirect after the delay slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            redirect_valid       <= 1'b0;
            redirect_pc          <= '0;
            instr_set_select_bit <= 1'b0;
            hazard_flush         <= 1'b0;
        end else begin
            redirect_valid <= (state_r == JLU_SLOT) && slot_done;
            hazard_flush   <= (state_r == JLU_SLOT) && slot_done
                              && barrier_r;
            if ((state_r == JLU_SLOT) && slot_done) begin
                redirect_pc          <= tgt_r;
                instr_set_select_bit <= mode_pend_r;
            end
        end
    end

    jlu_hazard_track u_haz (
        .aclk    (aclk),
        .aresetn (aresetn),
        .haz_set (cp0_hazard_set),
        .snap    (jump_go && barrier_dec),
        .clear   (hazard_flush),
        .pending (hazard_pending)
    );

    jlu_fetch_check u_fchk (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .arm         (redirect_valid),
        .err_in      (err_pend_r),
        .fetch_valid (fetch_valid),
        .addr_err    (addr_err_exc)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            jump_cnt_r <= '0;
        end else if (jump_go) begin
            jump_cnt_r <= jump_cnt_r + 32'h1;
        end
    end

    // Register decode: {hit, index}
    function automatic logic [2:0] reg_dec(input logic [AW-1:0] a);
        logic [7:0] off;
        off = 8'(a);
        unique case (off)
            CTRL_OFF:   reg_dec = 3'h4;
            STATUS_OFF: reg_dec = 3'h5;
            TARGET_OFF: reg_dec = 3'h6;
            COUNT_OFF:  reg_dec = 3'h7;
            default:    reg_dec = 3'h0;
        endcase
    endfunction

    // AXI4-Lite write path
    logic          aw_full_r;
    logic          w_full_r;
    logic [AW-1:0] awaddr_r;
    logic [31:0]   wdata_r;
    logic [3:0]    wstrb_r;
    logic [2:0]    wsel;
    logic          wr_do;

    always_comb begin
        s_axi_awready = !aw_full_r;
        s_axi_wready  = !w_full_r;
        wsel          = reg_dec(awaddr_r);
        wr_do         = aw_full_r && w_full_r && !s_axi_bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_do) begin
                w_full_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wsel[2] ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_do && (wsel == 3'h4) && wstrb_r[0]) begin
            ctrl_r <= wdata_r[1:0];
        end
    end

    // AXI4-Lite read path
    logic [2:0]  rsel;
    logic [31:0] rmux;

    always_comb begin
        s_axi_arready = !s_axi_rvalid;
        rsel          = reg_dec(s_axi_araddr);
        unique case (rsel)
            3'h4:    rmux = {30'h0, ctrl_r};
            3'h5:    rmux = {27'h0, hazard_pending, exch_r,
                             state_r, instr_set_select_bit};
            3'h6:    rmux = tgt_r[31:0];
            3'h7:    rmux = jump_cnt_r;
            default: rmux = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rmux;
            s_axi_rresp  <= rsel[2] ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_jlr_go;
        take && is_jlr;
    endsequence
    sequence s_exch_go;
        take && is_exch && cmp_on;
    endsequence

    a_link_plus_eight: assert property (
        s_jlr_go |=> link_wr.we
            && link_wr.data == $past(issue_req.pc) + LINK_STEP)
        else $error("link value is not jump address plus 8");
    a_exch_link_ra: assert property (
        s_exch_go |=> link_wr.we && link_wr.idx == LINK_REG_RA)
        else $error("exchange link not in register 31");
    a_exch_link_mode: assert property (
        s_exch_go |=> link_wr.data[0] == $past(instr_set_select_bit))
        else $error("exchange link bit 0 differs from mode");
    a_exch_reserved: assert property (
        take && is_exch && !cmp_on |=> resv_instr_exc && !link_wr.we)
        else $error("exchange without compressed isa not refused");
    a_target_bit_zero: assert property (
        redirect_valid |-> !redirect_pc[0])
        else $error("target bit 0 is set");
    a_redir_after_slot: assert property (
        redirect_valid |-> $past(slot_done)
            && $past(state_r) == JLU_SLOT)
        else $error("redirect before delay slot completed");
    a_mode_from_src: assert property (
        s_jlr_go ##0 cmp_on ##1 slot_done |=>
            instr_set_select_bit == $past(issue_req.rs_val[0], 2))
        else $error("mode bit not loaded from source bit 0");
    a_exch_toggle: assert property (
        s_exch_go ##1 slot_done |=>
            instr_set_select_bit != $past(instr_set_select_bit, 2))
        else $error("exchange jump did not toggle mode");
    a_exch_target: assert property (
        s_exch_go ##1 slot_done |=>
            redirect_pc[63:REGION_LO] ==
                $past(slot_pc[63:REGION_LO], 2)
            && redirect_pc[REGION_LO-1:0] ==
                $past({issue_req.instr[INDEX_HI:0], 2'b00}, 2))
        else $error("exchange target formed wrongly");
    a_barrier_flush: assert property (
        take && barrier_dec ##1 slot_done |=> hazard_flush)
        else $error("barrier jump gave no hazard flush");
    a_misalign_fault: assert property (
        s_jlr_go ##0 cmp_on && issue_req.rs_val[1:0] == 2'b10
            ##1 slot_done ##2 fetch_valid |=> addr_err_exc)
        else $error("misaligned target fetched without fault");
endmodule // jlu_jump_unit
`default_nettype wire

// ### verification/register_jump_link_unit_bench.sv
/* Self-checking bench of the register jump and link unit.
   Assumes jlu_pkg and rtl/jlu_*.sv are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
 $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module register_jump_link_unit_bench import jlu_pkg::*;;
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic        issue_valid = 0, slot_done = 0, cp0_hazard_set = 0;
    logic        fetch_valid = 0, issue_ready, redirect_valid;
    jlu_req_t    issue_req = '0;
    jlu_link_t   link_wr;
    logic [63:0] redirect_pc;
    logic        instr_set_select_bit, hazard_flush, hazard_pending;
    logic        resv_instr_exc, addr_err_exc;
    int          mismatches = 0, cmp_count = 0;
    logic        mode_exp = 0;

    jlu_jump_unit i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .issue_valid, .issue_ready,
        .issue_req, .slot_done, .cp0_hazard_set, .fetch_valid, .link_wr,
        .redirect_valid, .redirect_pc, .instr_set_select_bit,
        .hazard_flush, .hazard_pending, .resv_instr_exc, .addr_err_exc
    );

    initial forever #5 aclk = ~aclk;

    function automatic logic [31:0] jalr(input logic [4:0] rd,
                                         input logic hb);
        // Source field 4 differs from every link register used
        return {6'h00, 5'h04, 5'h00, rd, hb, 4'h0, 6'h09};
    endfunction

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        logic ha, hw, hb;
        hb = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!hb) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            r  = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        logic ha, hr;
        hr = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!hr) begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) s_axi_rready <= 1'b0;
        end
    endtask

    // One jump: take, link, stalled delay slot, redirect, target fetch
    task automatic jump(input logic [63:0] pc, input logic [31:0] ins,
        input logic [63:0] rs, input logic sh, input jlu_link_t lk,
        input logic [63:0] tpc, input logic fl, input logic er,
        input int st);
        @(posedge aclk);
        issue_req   <= '{pc: pc, instr: ins, rs_val: rs};
        issue_valid <= 1'b1;
        @(negedge aclk);
        `CHK(issue_ready, 1'b1)
        @(posedge aclk);
        issue_valid    <= 1'b0;
        cp0_hazard_set <= sh;
        // Delay slot is a plain instruction, st cycles of stall
        slot_done      <= (st == 0);
        @(negedge aclk);
        `CHK(link_wr, lk)
        for (int i = 0; i < st; i++) begin
            @(posedge aclk);
            cp0_hazard_set <= 1'b0;
            slot_done      <= (i == st - 1);
            @(negedge aclk);
            `CHK(redirect_valid, 1'b0)
        end
        @(posedge aclk);
        cp0_hazard_set <= 1'b0;
        slot_done      <= 1'b0;
        @(negedge aclk);
        `CHK(redirect_valid, 1'b1)
        `CHK(redirect_pc, tpc)
        `CHK(instr_set_select_bit, mode_exp)
        `CHK(hazard_flush, fl)
        @(posedge aclk);
        fetch_valid <= 1'b1;
        @(posedge aclk);
        fetch_valid <= 1'b0;
        @(negedge aclk);
        `CHK(addr_err_exc, er)
    endtask

    task automatic haz_pulse;
        @(posedge aclk);
        cp0_hazard_set <= 1'b1;
        @(posedge aclk);
        cp0_hazard_set <= 1'b0;
        @(negedge aclk);
        `CHK(hazard_pending, 1'b1)
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(CTRL_OFF, d, r);
        `CHK({r, d[1:0]}, {RESP_OKAY, CTRL_RST})
        axi_wr(8'h40, 32'hffffffff, r);
        `CHK(r, RESP_DECERR)
        axi_rd(8'h40, d, r);
        `CHK({r, d}, {RESP_DECERR, 32'h0})
        axi_rd(STATUS_OFF, d, r);
        `CHK(d[4:0], 5'h00)
    endtask

    task automatic t_link;
        mode_exp = 1'b1;
        jump(64'h1000, jalr(5'h05, 1'b0), 64'h401003, 1'b0,
             '{1'b1, 5'h05, 64'h1008}, 64'h401002, 1'b0, 1'b0, 0);
        mode_exp = 1'b0;
        jump(64'h2000, jalr(5'h06, 1'b0), 64'h402002, 1'b0,
             '{1'b1, 5'h06, 64'h2008}, 64'h402002, 1'b0, 1'b1, 0);
    endtask

    task automatic t_barrier;
        logic [1:0] r;
        haz_pulse;
        jump(64'h3000, jalr(5'h07, 1'b1), 64'h5000, 1'b1,
             '{1'b1, 5'h07, 64'h3008}, 64'h5000, 1'b1, 1'b0, 2);
        `CHK(hazard_pending, 1'b1)
        jump(64'h3100, jalr(5'h07, 1'b1), 64'h5100, 1'b0,
             '{1'b1, 5'h07, 64'h3108}, 64'h5100, 1'b1, 1'b0, 0);
        `CHK(hazard_pending, 1'b0)
        axi_wr(CTRL_OFF, 32'h1, r);
        haz_pulse;
        jump(64'h3200, jalr(5'h07, 1'b1), 64'h5200, 1'b0,
             '{1'b1, 5'h07, 64'h3208}, 64'h5200, 1'b0, 1'b0, 2);
        `CHK(hazard_pending, 1'b1)
        axi_wr(CTRL_OFF, 32'h3, r);
    endtask

    task automatic t_exch;
        mode_exp = 1'b1;
        jump(64'h1_0fff_fffc, {6'h1d, 26'h0123456}, 64'h0, 1'b0,
             '{1'b1, 5'h1f, 64'h1_1000_0004}, 64'h1_1048_d158,
             1'b0, 1'b0, 0);
        mode_exp = 1'b0;
        jump(64'h2000, {6'h1d, 26'h0000010}, 64'h0, 1'b0,
             '{1'b1, 5'h1f, 64'h2009}, 64'h40, 1'b0, 1'b0, 1);
    endtask

    task automatic t_nocomp;
        logic [1:0] r;
        logic       hit;
        logic [31:0] d;
        hit = 1'b0;
        axi_wr(CTRL_OFF, 32'h2, r);
        @(posedge aclk);
        issue_req   <= '{pc: 64'h4000, instr: {6'h1d, 26'h10}, rs_val: 64'h0};
        issue_valid <= 1'b1;
        @(posedge aclk);
        issue_valid <= 1'b0;
        repeat (3) begin
            @(negedge aclk);
            hit = hit | resv_instr_exc;
            `CHK(link_wr.we, 1'b0)
        end
        `CHK(hit, 1'b1)
        jump(64'h4100, jalr(5'h08, 1'b0), 64'h5003, 1'b0,
             '{1'b1, 5'h08, 64'h4108}, 64'h5002, 1'b0, 1'b1, 2);
        // Eight jumps taken so far; the refused exchange is not one
        axi_rd(COUNT_OFF, d, r);
        `CHK({r, d}, {RESP_OKAY, 32'h8})
        axi_rd(TARGET_OFF, d, r);
        `CHK({r, d}, {RESP_OKAY, 32'h5002})
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_link;
        t_barrier;
        t_exch;
        t_nocomp;
        tally_and_finish;
    end

    // Whole run needs about 100 cycles
    initial begin
        #20000;
        mismatches++;
        tally_and_finish;
    end
endmodule // register_jump_link_unit_bench
`default_nettype wire
